/* File: scr_regs.sv */
`timescale 1ns/10ps
`include "scr_cfg.svh"
module scr_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire scr_pkg::scr_req_s req,
    input wire scr_pkg::scr_byte_t live_status,
    output scr_pkg::scr_byte_t rdata,
    output scr_pkg::scr_byte_t base_out,
    output scr_pkg::scr_byte_t ctrl_out,
    output scr_pkg::scr_byte_t wo_out
);
    import scr_pkg::*;
    scr_state_s st;
    scr_state_s next_st;
    scr_byte_t rmux;
    logic wr_base;
    logic wr_clear;
    logic wr_set;
    logic wr_toggle;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_wo;
    logic wr_dbg;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        wr_base = req.wr && req.addr == `SCR_OFS_BASE;
        wr_clear = req.wr && req.addr == `SCR_OFS_CLEAR;
        wr_set = req.wr && req.addr == `SCR_OFS_SET;
        wr_toggle = req.wr && req.addr == `SCR_OFS_TOGGLE;
        wr_ctrl = req.wr && req.addr == `SCR_OFS_CTRL;
        wr_stat = req.wr && req.addr == `SCR_OFS_STAT;
        wr_wo = req.wr && req.addr == `SCR_OFS_WO;
        wr_dbg = req.wr && req.addr == `SCR_OFS_DBG;

        if (wr_base) begin
            next_st.base = req.wdata;
        end
        if (wr_clear) begin
            next_st.base = st.base & ~req.wdata;
        end
        if (wr_set) begin
            next_st.base = st.base | req.wdata;
        end
        if (wr_toggle) begin
            next_st.base = st.base ^ req.wdata;
        end
        if (req.wr && req.addr == `SCR_OFS_CTRL) begin
            next_st.ctrl = req.wdata & `SCR_CTRL_MASK;
        end
        if (req.wr && req.addr == `SCR_OFS_WO) begin
            next_st.wo = req.wdata;
        end
        if (req.wr && req.addr == `SCR_OFS_DBG) begin
            next_st.dbg = req.wdata & `SCR_DBG_MASK;
        end
        // Status offset has no storage, so writes there vanish
        case (req.addr)
            `SCR_OFS_BASE, `SCR_OFS_CLEAR, `SCR_OFS_SET, `SCR_OFS_TOGGLE: begin
                rmux = st.base;
            end
            `SCR_OFS_CTRL: begin
                rmux = st.ctrl;
            end
            `SCR_OFS_STAT: begin
                rmux = live_status;
            end
            `SCR_OFS_DBG: begin
                rmux = st.dbg;
            end
            default: begin
                rmux = 8'h00;
            end
        endcase
        next_st.rdata = req.rd ? rmux : 8'h00;
        if (soft_rst) begin
            // Debug register survives so a debugger keeps its setup
            next_st.base = `SCR_RST_BASE;
            next_st.ctrl = `SCR_RST_CTRL;
            next_st.wo = `SCR_RST_WO;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign rdata = st.rdata;
    assign base_out = st.base;
    assign ctrl_out = st.ctrl;
    assign wo_out = st.wo;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Checks sample pre-edge values, so a same-cycle soft reset is excluded from the checks on base, ctrl and wo

    a_clear_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_clear && !soft_rst
        |=> base_out == ($past(base_out) & ~$past(req.wdata)))
        else $error("clear alias wrong");

    a_set_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_set && !soft_rst
        |=> base_out == ($past(base_out) | $past(req.wdata)))
        else $error("set alias wrong");

    a_toggle_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_toggle && !soft_rst
        |=> base_out == ($past(base_out) ^ $past(req.wdata)))
        else $error("toggle alias wrong");

    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_ctrl && !soft_rst
        |=> ctrl_out == ($past(req.wdata) & `SCR_CTRL_MASK))
        else $error("ctrl write wrong");

    a_wo_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_wo && !soft_rst
        |=> wo_out == $past(req.wdata))
        else $error("write-only store wrong");

    a_dbg_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_dbg
        |=> st.dbg == ($past(req.wdata) & `SCR_DBG_MASK))
        else $error("debug write wrong");

    a_stat_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_stat && !soft_rst
        |=> $stable(base_out) && $stable(ctrl_out) && $stable(wo_out) && $stable(st.dbg))
        else $error("status write changed state");

    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !req.rd
        |=> rdata == 8'h00)
        else $error("read data without read");

    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.rd && req.addr[3]
        |=> rdata == 8'h00)
        else $error("unmapped read nonzero");

    // ----------------------------------------
    // Per-bit alias checks
    // ----------------------------------------
    // One instance per bit, so a fault names the bit that moved
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            a_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (wr_clear || wr_set || wr_toggle) && !soft_rst && !req.wdata[gi]
                |=> base_out[gi] == $past(base_out[gi]))
                else $error("alias changed an unselected bit");
        end
    endgenerate

    // ----------------------------------------
    // Register and reset checks
    // ----------------------------------------
    a_base_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_base && !soft_rst |=> base_out == $past(req.wdata))
        else $error("base write wrong");
    a_alias_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.rd && req.addr <= `SCR_OFS_TOGGLE |=> rdata == $past(base_out))
        else $error("alias read mismatch");
    a_stat_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.rd && req.addr == `SCR_OFS_STAT |=> rdata == $past(live_status))
        else $error("status read wrong");
    a_resv_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.rd && req.addr == `SCR_OFS_CTRL |=> (rdata & ~`SCR_CTRL_MASK) == 8'h00)
        else $error("reserved bits nonzero");
    a_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        soft_rst && !wr_dbg
        |=> base_out == `SCR_RST_BASE && ctrl_out == `SCR_RST_CTRL && wo_out == `SCR_RST_WO
            && st.dbg == $past(st.dbg))
        else $error("soft reset wrong");
    a_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !req.wr && !soft_rst |=> $stable(base_out) && $stable(ctrl_out))
        else $error("base changed without write");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_set_then_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_set ##1 wr_clear);
    c_toggle_twice: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_toggle ##1 wr_toggle);
    c_soft_rst: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_base ##1 soft_rst);
    c_stat_read: cover property (@(posedge sys_clk) disable iff (!rst_n) req.rd && req.addr == `SCR_OFS_STAT);
    c_wo_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_wo);
endmodule : scr_regs

/* File: scr_cfg.svh */
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCR_OFS_BASE 4'h0
`define SCR_OFS_CLEAR 4'h1
`define SCR_OFS_SET 4'h2
`define SCR_OFS_TOGGLE 4'h3
`define SCR_OFS_CTRL 4'h4
`define SCR_OFS_STAT 4'h5
`define SCR_OFS_WO 4'h6
`define SCR_OFS_DBG 4'h7
// ----------------------------------------
// Field masks and reset values
// ----------------------------------------
`define SCR_CTRL_MASK 8'h3F
`define SCR_DBG_MASK 8'h0F
`define SCR_RST_BASE 8'h00
`define SCR_RST_CTRL 8'h00
`define SCR_RST_WO 8'h00
`define SCR_RST_DBG 8'h00
`endif

/* File: scr_pkg.sv */
package scr_pkg;
    typedef logic [7:0] scr_byte_t;
    typedef logic [3:0] scr_addr_t;
    typedef struct packed {
        logic wr;
        logic rd;
        scr_addr_t addr;
        scr_byte_t wdata;
    } scr_req_s;
    typedef struct packed {
        scr_byte_t base;
        scr_byte_t ctrl;
        scr_byte_t wo;
        scr_byte_t dbg;
        scr_byte_t rdata;
    } scr_state_s;
endpackage : scr_pkg

/* File: scr_cpu_model.sv */
`timescale 1ns/10ps
`include "scr_cfg.svh"
// ----
// Core on the register bus
// ----
module scr_cpu_model (
    input wire logic sys_clk,
    output scr_pkg::scr_req_s req
);
    import scr_pkg::*;
    initial req = '0;
    // One strobe per access; idle cycle between keeps strobes distinct
    task automatic xfer(input logic w, input scr_addr_t a, input scr_byte_t d);
        @(posedge sys_clk);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: (a == `SCR_OFS_CTRL) ? (d & `SCR_CTRL_MASK) : d};
        @(posedge sys_clk);
        #1;
        req = '0;
    endtask : xfer
endmodule : scr_cpu_model

/* File: scr_tb.sv */
`timescale 1ns/10ps
module set_clear_toggle_register_pair_tb;
    import scr_pkg::*;
    logic sys_clk, rst_n, soft_rst;
    scr_req_s req;
    scr_byte_t live_status, rdata, base_out, ctrl_out, wo_out, lfsr, d;
    scr_byte_t m [8];
    scr_addr_t a;
    int miscompares, samples_checked;
    scr_regs scr_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst), .req(req),
        .live_status(live_status), .rdata(rdata), .base_out(base_out), .ctrl_out(ctrl_out), .wo_out(wo_out));
    scr_cpu_model scr_cpu_model_inst (.sys_clk(sys_clk), .req(req));
    // ----
    // Helpers
    // ----
    function automatic scr_byte_t nx(input scr_byte_t l);
        return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    endfunction : nx
    task automatic chk(input scr_byte_t got, input scr_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rd(input scr_byte_t got, input scr_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t rdata=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic tally_and_finish();
        $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Run needs about 3 us; generous margin
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst_n = 0;
        soft_rst = 0;
        live_status = 8'h00;
        lfsr = 8'h21;
        m = '{default: 8'h00};
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1;
        chk(base_out | ctrl_out | wo_out, 8'h00);
        for (int i = 0; i < 200; i++) begin
            lfsr = nx(lfsr);
            a = lfsr[3:0];
            lfsr = nx(lfsr);
            d = lfsr;
            live_status = ~lfsr;
            scr_cpu_model_inst.xfer(1'b1, a, d);
            case (a)
                4'h0: m[0] = d;
                4'h1: m[0] &= ~d;
                4'h2: m[0] |= d;
                4'h3: m[0] ^= d;
                4'h4: m[4] = d & 8'h3F;
                4'h6: m[6] = d;
                4'h7: m[7] = d & 8'h0F;
                default: ;
            endcase
            chk(base_out, m[0]);
            chk({ctrl_out, wo_out}, {m[4], m[6]});
            a = nx(lfsr) % 16;
            if (a != 4'h6) begin
                scr_cpu_model_inst.xfer(1'b0, a, 8'h00);
                chk_rd(rdata, (a < 4) ? m[0] : (a == 4'h5) ? live_status : (a < 8) ? m[a] : 8'h00);
            end
            if (i == 100) begin
                soft_rst = 1;
                @(posedge sys_clk);
                #1 soft_rst = 0;
                m[0] = 0; m[4] = 0; m[6] = 0;
                chk(base_out | ctrl_out | wo_out, 8'h00);
                scr_cpu_model_inst.xfer(1'b0, 4'h7, 8'h00);
                chk_rd(rdata, m[7]);
            end
        end
        tally_and_finish();
    end
endmodule : set_clear_toggle_register_pair_tb
